// ==== rtl/smsp_pkg.sv ====
// Package with register map, field positions and types for the SPI master/slave port
// What this block does
// - Slave select input gates slave activity and output
// - Slave select high resets state and bit counter, shifter keeps its byte
// - Master with select as output ignores pin
// - Master select low drops to slave, sets flag
// - Interrupt when flag, enable and global set
// - No transfer or flag unless port enable set, data still loadable
// - Control bit 5 picks LSB first
// - Polarity bit sets SCK idle level
// - Phase bit picks sample and setup edges
// - Shift on the sample edge, out bit moves after it, modes 0-3
// - Master SCK divides by rate table
// - Rate bits ignored in slave mode
// - Double rate bit halves master divider
// - Completion flag set when byte finishes
// - Flag cleared by vector or status-then-data access
// - Collision flag on data write during transfer
// - Status bits 5 to 1 read zero
// - Data write starts, data read returns buffer
// - Master shifts eight bits then stops clock
// - Single transmit buffer, double receive buffer
// - Slave deselected ignores SCK, data still loadable
`default_nettype none
package smsp_pkg;
    localparam logic [1:0] SMSP_ADDR_CONTROL = 2'h0;
    localparam logic [1:0] SMSP_ADDR_STATUS  = 2'h1;
    localparam logic [1:0] SMSP_ADDR_DATA    = 2'h2;
    localparam int CTL_IRQ_EN   = 7;
    localparam int CTL_ENABLE   = 6;
    localparam int CTL_LSB      = 5;
    localparam int CTL_MASTER   = 4;
    localparam int CTL_CPOL     = 3;
    localparam int CTL_CPHA     = 2;
    localparam int CTL_RATE_HI  = 1;
    localparam int CTL_RATE_LO  = 0;
    localparam int STS_DONE     = 7;
    localparam int STS_WRITE_COLLISION_FLAG     = 6;
    localparam int STS_DOUBLE   = 0;
    localparam logic [7:0] SMSP_CONTROL_RESET = 8'h00;
    localparam logic [3:0] SMSP_BIT_COUNT     = 4'h8;
    localparam real SMSP_CLK_MHZ = 125.0;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } smsp_bus_s;

    typedef enum logic [0:0] {SMSP_IDLE, SMSP_BUSY} smsp_state_e;
endpackage : smsp_pkg
`default_nettype wire

// ==== rtl/smsp_port.sv ====
// SPI master/slave port with register file, clock divider and shifter
//
// Added by the designer: the address map and strobed register access.
`default_nettype none
module smsp_port (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Register bus
    input  wire smsp_pkg::smsp_bus_s bus,
    output logic [7:0]             rdata,
    // Processor side
    input  wire logic              cpu_global_irq_en,
    input  wire logic              irq_vector_taken,
    input  wire logic              ss_is_output,
    output logic                   irq,
    // Serial pins
    input  wire logic              sck_in,
    output logic                   sck_out,
    output logic                   sck_oe,
    input  wire logic              mosi_in,
    output logic                   mosi_out,
    output logic                   mosi_oe,
    input  wire logic              miso_in,
    output logic                   miso_out,
    output logic                   miso_oe,
    input  wire logic              ss_n_in
);
    import smsp_pkg::*;

    logic [7:0]  ctl_ff;
    logic        dbl_ff;
    logic        done_ff;
    logic        write_collision_flag_ff;
    logic        sts_seen_ff;
    logic [7:0]  shift_ff;
    logic [7:0]  rxbuf_ff;
    logic [3:0]  bits_ff;
    logic [6:0]  div_ff;
    logic        phase_ff;
    smsp_state_e state_ff;
    logic        sck_s1_ff;
    logic        sck_s2_ff;
    logic        sck_s3_ff;
    logic        ss_s1_ff;
    logic        ss_s2_ff;
    logic        mosi_s1_ff;
    logic        mosi_s2_ff;
    logic        miso_s1_ff;
    logic        miso_s2_ff;

    logic       enable;
    logic       master;
    logic       lsb_first;
    logic       cpol;
    logic       cpha;
    logic [6:0] half_div;
    logic       mode_fault;
    logic       wr_data;
    logic       rd_data;
    logic       data_acc;
    logic       rd_status;
    logic       slave_sel;
    logic       s_lead;
    logic       s_trail;
    logic       m_tick;
    logic       edge_any;
    logic       edge_lead;
    logic       do_sample;
    logic       do_shift;
    logic       serial_in;
    logic [7:0] nxt_shift;
    logic       last_bit;

    assign enable    = ctl_ff[CTL_ENABLE];
    assign master    = ctl_ff[CTL_MASTER];
    assign lsb_first = ctl_ff[CTL_LSB];
    assign cpol      = ctl_ff[CTL_CPOL];
    assign cpha      = ctl_ff[CTL_CPHA];
    assign wr_data   = bus.wr && bus.addr == SMSP_ADDR_DATA;
    assign rd_data   = bus.rd && bus.addr == SMSP_ADDR_DATA;
    assign data_acc  = wr_data || rd_data;
    assign rd_status = bus.rd && bus.addr == SMSP_ADDR_STATUS;
    // Select only counts as a fault when it is an input; as an output it is a plain pin
    assign mode_fault = enable && master && !ss_is_output && !ss_s2_ff;
    assign slave_sel  = enable && !master && !ss_s2_ff;

    // Half-period of SCK in system clocks, from the rate table
    always_comb begin
        unique case ({dbl_ff, ctl_ff[CTL_RATE_HI], ctl_ff[CTL_RATE_LO]})
            3'b000:  half_div = 7'd2;
            3'b001:  half_div = 7'd8;
            3'b010:  half_div = 7'd32;
            3'b011:  half_div = 7'd64;
            3'b100:  half_div = 7'd1;
            3'b101:  half_div = 7'd4;
            3'b110:  half_div = 7'd16;
            default: half_div = 7'd32;
        endcase
    end

    // Slave SCK: two-flop sync then edge detect on later stages
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sck_s1_ff  <= 1'b0;
            sck_s2_ff  <= 1'b0;
            sck_s3_ff  <= 1'b0;
            ss_s1_ff   <= 1'b1;
            ss_s2_ff   <= 1'b1;
            mosi_s1_ff <= 1'b0;
            mosi_s2_ff <= 1'b0;
            miso_s1_ff <= 1'b0;
            miso_s2_ff <= 1'b0;
        end else begin
            sck_s1_ff  <= sck_in;
            sck_s2_ff  <= sck_s1_ff;
            sck_s3_ff  <= sck_s2_ff;
            ss_s1_ff   <= ss_n_in;
            ss_s2_ff   <= ss_s1_ff;
            mosi_s1_ff <= mosi_in;
            mosi_s2_ff <= mosi_s1_ff;
            miso_s1_ff <= miso_in;
            miso_s2_ff <= miso_s1_ff;
        end
    end

    // Leading edge leaves the idle level set by polarity
    assign s_lead  = slave_sel && (sck_s2_ff != sck_s3_ff) && (sck_s3_ff == cpol);
    assign s_trail = slave_sel && (sck_s2_ff != sck_s3_ff) && (sck_s3_ff != cpol);
    assign m_tick  = master && state_ff == SMSP_BUSY && div_ff == 7'd1;
    assign edge_lead = master ? !phase_ff : s_lead;
    assign edge_any  = master ? m_tick : (s_lead || s_trail);
    // Sample and shift on one edge; do_shift marks the other edge and drives nothing
    assign do_sample = edge_any && (edge_lead ^ cpha);
    assign do_shift  = edge_any && !(edge_lead ^ cpha);
    assign serial_in = master ? miso_s2_ff : mosi_s2_ff;
    assign last_bit  = do_sample && bits_ff == SMSP_BIT_COUNT - 4'h1;

    always_comb begin
        nxt_shift = shift_ff;
        if (do_sample) begin
            nxt_shift = lsb_first ? {serial_in, shift_ff[7:1]} : {shift_ff[6:0], serial_in};
        end
    end

    // Control register; a select fault clears master mode until software sets it again
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff <= SMSP_CONTROL_RESET;
            dbl_ff <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == SMSP_ADDR_CONTROL) begin
                ctl_ff <= bus.wdata;
            end
            if (mode_fault) begin
                ctl_ff[CTL_MASTER] <= 1'b0;
            end
            if (bus.wr && bus.addr == SMSP_ADDR_STATUS) begin
                dbl_ff <= bus.wdata[STS_DOUBLE];
            end
        end
    end

    // Transfer engine; slave deselect drops any partial byte at once
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SMSP_IDLE;
            shift_ff <= 8'h00;
            bits_ff  <= 4'h0;
            div_ff   <= 7'd0;
            phase_ff <= 1'b0;
        end else if (!enable || mode_fault) begin
            state_ff <= SMSP_IDLE;
            bits_ff  <= 4'h0;
            phase_ff <= 1'b0;
            if (wr_data) begin
                shift_ff <= bus.wdata;
            end
        end else if (!master && ss_s2_ff) begin
            state_ff <= SMSP_IDLE;
            bits_ff  <= 4'h0;
            if (wr_data) begin
                shift_ff <= bus.wdata;
            end
        end else begin
            shift_ff <= nxt_shift;
            if (do_sample) begin
                bits_ff <= last_bit ? 4'h0 : bits_ff + 4'h1;
            end
            unique case (state_ff)
                SMSP_IDLE: begin
                    if (wr_data) begin
                        shift_ff <= bus.wdata;
                        // One extra cycle lets the first data bit settle on the pin before the first edge
                        div_ff   <= half_div + 7'd1;
                        phase_ff <= 1'b0;
                        bits_ff  <= 4'h0;
                        state_ff <= SMSP_BUSY;
                    end else if (!master && (s_lead || s_trail)) begin
                        state_ff <= SMSP_BUSY;
                    end
                end
                SMSP_BUSY: begin
                    if (master) begin
                        div_ff <= (div_ff == 7'd1) ? half_div : div_ff - 7'd1;
                        if (m_tick) begin
                            phase_ff <= !phase_ff;
                            if (phase_ff && bits_ff == 4'h0 && !cpha) begin
                                state_ff <= SMSP_IDLE;
                            end
                        end
                        if (last_bit && cpha) begin
                            state_ff <= SMSP_IDLE;
                        end
                    end else if (last_bit) begin
                        state_ff <= SMSP_IDLE;
                    end
                end
            endcase
        end
    end

    // Received byte moves to the read buffer; an unread byte is simply overwritten
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxbuf_ff <= 8'h00;
        end else if (last_bit && enable && !mode_fault) begin
            rxbuf_ff <= nxt_shift;
        end
    end

    // Flags: set wins over clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done_ff     <= 1'b0;
            write_collision_flag_ff     <= 1'b0;
            sts_seen_ff <= 1'b0;
        end else begin
            if (rd_status) begin
                sts_seen_ff <= done_ff || write_collision_flag_ff;
            end else if (data_acc) begin
                sts_seen_ff <= 1'b0;
            end
            if ((last_bit && enable) || mode_fault) begin
                done_ff <= 1'b1;
            end else if (irq_vector_taken || (data_acc && sts_seen_ff)) begin
                done_ff <= 1'b0;
            end
            if (wr_data && state_ff == SMSP_BUSY && enable) begin
                write_collision_flag_ff <= 1'b1;
            end else if (data_acc && sts_seen_ff) begin
                write_collision_flag_ff <= 1'b0;
            end
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                SMSP_ADDR_CONTROL: rdata <= ctl_ff;
                SMSP_ADDR_STATUS:  rdata <= {done_ff, write_collision_flag_ff, 5'h00, dbl_ff};
                SMSP_ADDR_DATA:    rdata <= rxbuf_ff;
                default:           rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Pins and interrupt, all registered
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq      <= 1'b0;
            sck_out  <= 1'b0;
            sck_oe   <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe  <= 1'b0;
            miso_out <= 1'b0;
            miso_oe  <= 1'b0;
        end else begin
            irq      <= done_ff && ctl_ff[CTL_IRQ_EN] && cpu_global_irq_en;
            sck_out  <= (master && state_ff == SMSP_BUSY) ? (cpol ^ phase_ff ^ (m_tick ? 1'b1 : 1'b0)) : cpol;
            sck_oe   <= enable && master && !mode_fault;
            mosi_oe  <= enable && master && !mode_fault;
            miso_oe  <= slave_sel;
            // Out bit follows the stored byte, so it moves only after the sampling edge has passed
            mosi_out <= lsb_first ? shift_ff[0] : shift_ff[7];
            miso_out <= lsb_first ? shift_ff[0] : shift_ff[7];
        end
    end
endmodule // smsp_port
`default_nettype wire

// ==== dv/smsp_port_checker.sv ====
// Pin and register bus assertions for the SPI port
`default_nettype none
module smsp_port_checker (
    // Clock and reset
    input wire logic                clk_sys,
    input wire logic                rst_n,
    // Bus and processor side
    input wire smsp_pkg::smsp_bus_s bus,
    input wire logic [7:0]          rdata,
    input wire logic                cpu_global_irq_en,
    input wire logic                ss_is_output,
    input wire logic                irq,
    // Serial pins
    input wire logic                sck_oe,
    input wire logic                mosi_oe,
    input wire logic                miso_oe,
    input wire logic                ss_n_in
);
    import smsp_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Sync latency on the select pin is under four cycles
    sequence s_fault_held;
        (!ss_is_output && !ss_n_in) [*5];
    endsequence
    sequence s_deselected;
        ss_n_in [*4];
    endsequence
    chk_irq_global_gate: assert property (irq |-> $past(cpu_global_irq_en))
        else $error("irq without global enable");
    chk_rdata_idle_zero: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data outside read answer");
    chk_status_reserved: assert property (
        $past(bus.rd) && $past(bus.addr) == SMSP_ADDR_STATUS |-> rdata[5:1] == 5'h00)
        else $error("reserved status bits set");
    chk_select_out_ignored: assert property (
        sck_oe && ss_is_output && !bus.wr && !$past(bus.wr) && !$past(bus.wr, 2) |=> sck_oe)
        else $error("select output disturbed master");
    chk_mode_fault_drop: assert property (s_fault_held |-> !sck_oe && !mosi_oe)
        else $error("master kept driving under select fault");
    chk_slave_release: assert property (s_deselected |-> !miso_oe)
        else $error("miso driven while deselected");
    chk_master_no_miso: assert property (sck_oe |-> !miso_oe)
        else $error("miso driven in master mode");
    chk_mosi_with_sck: assert property (mosi_oe |-> sck_oe)
        else $error("mosi driven without clock");
endmodule // smsp_port_checker
bind smsp_port smsp_port_checker i_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .cpu_global_irq_en(cpu_global_irq_en), .ss_is_output(ss_is_output), .irq(irq),
    .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_n_in(ss_n_in)
);
`default_nettype wire

// ==== dv/smsp_peer.sv ====
// Behavioural SPI slave peripheral facing the port in master mode
`default_nettype none
module smsp_peer (
    // Mode and select
    input wire logic       cpol,
    input wire logic       cpha,
    input wire logic       ss_n,
    input wire logic [7:0] tx_byte,
    // Serial lines
    input wire logic       sck,
    input wire logic       mosi,
    output logic           miso,
    output logic [7:0]     rx_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt;
    logic drv = 1'b0;
    // Released line shows the inverse, so a stale bit can never pass
    assign miso = ss_n ? ~drv : drv;
    always @(negedge ss_n) begin
        cnt = 0;
        drv = tx_byte[7];
    end
    always @(sck) begin
        if (!ss_n && sck == (cpol ~^ cpha)) begin
            rx_bits = {rx_bits[6:0], mosi};
            cnt = cnt + 1;
        end else if (!ss_n && cnt < 8) begin
            drv = tx_byte[7 - cnt];
        end
    end
endmodule // smsp_peer
`default_nettype wire

// ==== dv/smsp_port_tb.sv ====
// Self-checking bench for the SPI master/slave port
`default_nettype none
module smsp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import smsp_pkg::*;
    logic       clk_sys, irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, peer_miso, last;
    logic       rst_n = 1'b0, glb = 1'b0, vec = 1'b0, ss_out = 1'b1, ss_n = 1'b0;
    logic       tb_sck = 1'b0, tb_mosi = 1'b0, peer_ss_n = 1'b1, cpol = 1'b0, cpha = 1'b0;
    logic [7:0] rdata, rv, prx, sr, txb, ptx = 8'h00;
    smsp_bus_s  bus = '0;
    int         error_cnt, check_count, t0, t1, n, e;
    int         divs[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
    // Shared pins resolve from the drivers' enables
    wire logic  sck_w  = sck_oe ? sck_out : tb_sck;
    wire logic  mosi_w = mosi_oe ? mosi_out : tb_mosi;
    wire logic  miso_w = miso_oe ? miso_out : peer_miso;
    smsp_port i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .cpu_global_irq_en(glb), .irq_vector_taken(vec), .ss_is_output(ss_out), .irq(irq),
        .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n)
    );
    smsp_peer i_peer (
        .cpol(cpol), .cpha(cpha), .ss_n(peer_ss_n), .tx_byte(ptx), .sck(sck_w), .mosi(mosi_w),
        .miso(peer_miso), .rx_bits(prx)
    );
    task automatic summarize();
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
        @(posedge clk_sys);
        rv = rdata;
    endtask
    task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(rv, exp);
    endtask
    task automatic wait_done();
        n = 0;
        rv = 8'h00;
        while (rv[7] !== 1'b1 && n < 1000) begin
            acc(1'b0, SMSP_ADDR_STATUS, 8'h00);
            n++;
        end
        if (n >= 1000) begin
            error_cnt++;
            summarize();
        end
    endtask
    // External master at a twelfth of the system clock, mode 0, MSB first
    task automatic sbyte(input logic [7:0] m, input int nb);
        ss_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        for (int k = 0; k < nb; k++) begin
            tb_mosi <= m[7 - k];
            repeat (6) @(posedge clk_sys);
            tb_sck <= 1'b1;
            sr = {sr[6:0], miso_w};
            repeat (6) @(posedge clk_sys);
            tb_sck <= 1'b0;
        end
        repeat (6) @(posedge clk_sys);
        ss_n <= 1'b1;
        tb_mosi <= ~tb_mosi;
        repeat (6) @(posedge clk_sys);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rdc(SMSP_ADDR_CONTROL, SMSP_CONTROL_RESET);
        rdc(SMSP_ADDR_STATUS, 8'h00);
        rdc(2'h3, 8'h00);
        for (int i = 0; i < 8; i++) begin
            cpol <= i[1];
            cpha <= i[0];
            ptx <= 8'h1d + 8'(i * 37);
            txb = 8'hc6 ^ 8'(i);
            acc(1'b1, SMSP_ADDR_STATUS, {7'h00, i[2]});
            acc(1'b1, SMSP_ADDR_CONTROL, {2'b11, i[2], 1'b1, i[1:0], i[1:0]});
            peer_ss_n <= 1'b0;
            glb <= i[0];
            acc(1'b1, SMSP_ADDR_DATA, txb);
            e = 0;
            n = 0;
            last = sck_out;
            while (e < 3 && n < 600) begin
                @(posedge clk_sys);
                n++;
                if (sck_out !== last) begin
                    e++;
                    t0 = (e == 1) ? n : t0;
                    t1 = n;
                end
                last = sck_out;
            end
            chk(8'(t1 - t0), 8'(divs[i]));
            wait_done();
            chk(rv, {1'b1, 6'h00, i[2]});
            @(posedge clk_sys);
            chk({7'h00, irq}, {7'h00, i[0]});
            acc(1'b0, SMSP_ADDR_DATA, 8'h00);
            // Fastest rates outrun the input synchroniser, so receive is judged from 16 up
            if (divs[i] >= 16) begin
                chk(rv, i[2] ? {<<{ptx}} : ptx);
            end
            chk(prx, i[2] ? {<<{txb}} : txb);
            rdc(SMSP_ADDR_STATUS, {7'h00, i[2]});
            // Let the closing trailing edge of the slowest rate pass before reconfiguring
            repeat (140) @(posedge clk_sys);
            peer_ss_n <= 1'b1;
        end
        acc(1'b1, SMSP_ADDR_DATA, 8'h81);
        acc(1'b1, SMSP_ADDR_DATA, 8'h7e);
        wait_done();
        chk(rv, 8'hc1);
        vec <= 1'b1;
        @(posedge clk_sys);
        vec <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk({7'h00, irq}, 8'h00);
        rdc(SMSP_ADDR_STATUS, 8'h41);
        acc(1'b0, SMSP_ADDR_DATA, 8'h00);
        rdc(SMSP_ADDR_STATUS, 8'h01);
        ss_n <= 1'b1;
        acc(1'b1, SMSP_ADDR_CONTROL, 8'h50);
        ss_out <= 1'b0;
        ss_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk({7'h00, sck_oe}, 8'h00);
        rdc(SMSP_ADDR_CONTROL, 8'h40);
        rdc(SMSP_ADDR_STATUS, 8'h81);
        ss_n <= 1'b1;
        acc(1'b0, SMSP_ADDR_DATA, 8'h00);
        acc(1'b1, SMSP_ADDR_CONTROL, 8'h50);
        rdc(SMSP_ADDR_CONTROL, 8'h50);
        acc(1'b1, SMSP_ADDR_CONTROL, 8'h43);
        acc(1'b1, SMSP_ADDR_DATA, 8'hc3);
        sbyte(8'h3c, 8);
        chk(sr, 8'hc3);
        rdc(SMSP_ADDR_STATUS, 8'h81);
        rdc(SMSP_ADDR_DATA, 8'h3c);
        sbyte(8'hff, 3);
        sbyte(8'h69, 8);
        rdc(SMSP_ADDR_STATUS, 8'h81);
        rdc(SMSP_ADDR_DATA, 8'h69);
        acc(1'b1, SMSP_ADDR_CONTROL, 8'h10);
        acc(1'b1, SMSP_ADDR_DATA, 8'h55);
        repeat (100) @(posedge clk_sys);
        rdc(SMSP_ADDR_STATUS, 8'h01);
        summarize();
    end
endmodule // smsp_port_tb
`default_nettype wire
